// ---- pos_host.sv ----
// host model driving the start and entry-select pins of the sequencer
`timescale 1ns/1ns
`default_nettype none
`include "seq_params.svh"
module pos_host (
    // clock and handshake
    input wire logic i_sys_clk,
    input wire logic i_ready,
    // start request pins
    output logic o_start,
    output logic [`SEQ_ENTRY_W-1:0] o_select
);
    initial begin
        o_start = 1'b0;
        o_select = 8'h00;
    end

    // one full request; poke raises start again mid-run with a wrong number
    task automatic run_entry(input logic [7:0] num, input bit poke, output bit ok);
        int n;
        ok = 1'b0;
        n = 0;
        while (i_ready !== 1'b1 && n < 20000) begin
            @(negedge i_sys_clk);
            n++;
        end
        o_select = num;
        @(negedge i_sys_clk);
        o_start = 1'b1;
        n = 0;
        while (i_ready !== 1'b0 && n < 20) begin
            @(negedge i_sys_clk);
            n++;
        end
        ok = (i_ready === 1'b0);
        o_start = 1'b0;
        o_select = ~num;
        if (poke) begin
            repeat (3) @(negedge i_sys_clk);
            o_start = 1'b1;
            repeat (5) @(negedge i_sys_clk);
            o_start = 1'b0;
        end
        n = 0;
        while (i_ready !== 1'b1 && n < 20000) begin
            @(negedge i_sys_clk);
            n++;
        end
        ok = ok && (i_ready === 1'b1);
    endtask
endmodule // pos_host
`default_nettype wire

// ---- pos_sequencer.sv ----
// positioning operation sequencer with ready/start handshake
// What this block does
// - reverse-only wrap type turns reverse toward any target inside the range other than the current position
// - accepted start drops ready and begins the selected entry
// - ready rises again once the operation finishes and start is released
// - absolute type treats position as coordinate from home
// - incremental adds travel to command or feedback position
// - wrap absolute target taken from home, motion kept inside wrap range
// - wrap proximity picks the shorter rotation direction
// - forward-only wrap type moves only forward
// - push-motion runs at stored speed, no ramp, stops at target
// - push done flag tells whether pushing against a load happened
// - push travel outside signed 32-bit range raises data error alarm
// - push into excessive deviation zone raises overflow alarm
// - push direction follows sign of stored position minus command position
// - negative push speed uses its magnitude
// - wrap configured by enable, range, offset ratio, round offset, pulse count; offset_pct is not used by the logic
`timescale 1ns/1ns
`default_nettype none
`include "seq_params.svh"
module pos_sequencer
    import seq_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // host handshake pins
    input wire logic i_start,
    input wire logic [`SEQ_ENTRY_W-1:0] i_entry_select_inputs,
    output logic o_ready,
    // operation data of the selected entry, wrap setup
    input wire op_entry_t i_entry,
    input wire wrap_cfg_t i_wrap,
    // motor side
    input wire logic signed [`SEQ_POS_W-1:0] i_feedback_pos,
    input wire logic i_load_contact,
    input wire logic [`SEQ_DEV_W-1:0] i_dev_limit,
    // outputs
    output logic [`SEQ_ENTRY_W-1:0] o_entry_addr,
    output logic signed [`SEQ_POS_W-1:0] o_cmd_pos,
    output logic o_step,
    output logic o_dir_fwd,
    output logic o_push_done_flag,
    output logic o_wrap_zero_pulse,
    output logic o_alarm_data_err,
    output logic o_alarm_overflow
);
    seq_state_t state;
    logic start_m, start_s, load_m, load_s;
    logic [`SEQ_ENTRY_W-1:0] sel_m, sel_s;
    logic signed [`SEQ_POS_W-1:0] fb_m, fb_s;
    logic signed [`SEQ_POS_W-1:0] target;
    logic signed [`SEQ_SPEED_W-1:0] rate;
    logic is_push, step_run, step_pulse;
    logic signed [63:0] trav_w, wrap_span, rel, fwd_d, rvs_d, dev;
    logic [31:0] zero_spacing;
    logic signed [`SEQ_POS_W-1:0] next_cmd_pos;
    logic wrap_on;

    // pins cross from outside: two flops each
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            start_m <= 1'b0; start_s <= 1'b0;
            load_m <= 1'b0; load_s <= 1'b0;
            sel_m <= '0; sel_s <= '0;
            fb_m <= '0; fb_s <= '0;
        end else begin
            start_m <= i_start; start_s <= start_m;
            load_m <= i_load_contact; load_s <= load_m;
            sel_m <= i_entry_select_inputs; sel_s <= sel_m;
            fb_m <= i_feedback_pos; fb_s <= fb_m;
        end
    end

    function automatic logic signed [63:0] wrap_mod(input logic signed [63:0] v,
                                                    input logic signed [63:0] m);
        logic signed [63:0] r;
        r = (m > 0) ? v % m : v;
        if (r < 0) r = r + m;
        return r;
    endfunction

    // wrap range in steps from the revolution count and step scale
    always_comb begin
        wrap_span = 64'($unsigned(i_wrap.range_rev)) * 64'(`SEQ_STEPS_PER_REV);
        rel = 64'(i_entry.position) - 64'(i_wrap.round_offset);
        fwd_d = wrap_mod(rel - 64'(o_cmd_pos), wrap_span);
        rvs_d = (fwd_d == 0) ? 64'sd0 : wrap_span - fwd_d;
        case (i_entry.op)
            OP_INC_CMD: trav_w = 64'(i_entry.position);
            OP_INC_FB: trav_w = 64'(fb_s) + 64'(i_entry.position) - 64'(o_cmd_pos);
            OP_WRAP_ABS: trav_w = (fwd_d <= rvs_d) ? fwd_d : -rvs_d;
            OP_WRAP_NEAR: trav_w = (fwd_d <= rvs_d) ? fwd_d : -rvs_d;
            OP_WRAP_FWD: trav_w = fwd_d;
            OP_WRAP_RVS: trav_w = -rvs_d;
            OP_PUSH_ABS: trav_w = 64'(i_entry.position) - 64'(o_cmd_pos);
            default: trav_w = 64'(i_entry.position) - 64'(o_cmd_pos);
        endcase
        if (!i_wrap.enable && i_entry.op inside {OP_WRAP_ABS, OP_WRAP_NEAR,
                                                 OP_WRAP_FWD, OP_WRAP_RVS}) begin
            trav_w = 64'(i_entry.position) - 64'(o_cmd_pos);
        end
        dev = 64'(o_cmd_pos) - 64'(fb_s);
        if (dev < 0) dev = -dev;
        zero_spacing = (i_wrap.zero_pulses == 8'h00) ? 32'h0 :
            32'(wrap_span / 64'($unsigned(i_wrap.zero_pulses)));
        // an empty range would leave nothing to wrap into
        wrap_on = i_wrap.enable && (wrap_span != 64'sd0);
        // wrapped coordinates roll over at the range ends
        if (o_dir_fwd) begin
            if (wrap_on && 64'(o_cmd_pos) + 64'sd1 >= wrap_span) next_cmd_pos = '0;
            else next_cmd_pos = o_cmd_pos + 32'sd1;
        end else begin
            if (wrap_on && o_cmd_pos <= 32'sd0) next_cmd_pos = 32'(wrap_span - 64'sd1);
            else next_cmd_pos = o_cmd_pos - 32'sd1;
        end
    end

    // handshake: start only taken while ready
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_READY;
            o_entry_addr <= '0;
            target <= '0;
            rate <= '0;
            is_push <= 1'b0;
            o_dir_fwd <= 1'b1;
        end else begin
            case (state)
                ST_READY: begin
                    if (start_s) begin
                        o_entry_addr <= sel_s;
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // travel wider than 32 bits is refused
                    if (trav_w > 64'sd2147483647 || trav_w < -64'sd2147483648) begin
                        state <= ST_DONE;
                    end else begin
                        // target folded into the range so the wrapped position meets it
                        target <= wrap_on ? 32'(wrap_mod(64'(o_cmd_pos) + trav_w, wrap_span))
                                          : 32'(64'(o_cmd_pos) + trav_w);
                        o_dir_fwd <= (trav_w >= 0);
                        rate <= i_entry.speed[`SEQ_SPEED_W-1] ? -i_entry.speed
                                                              : i_entry.speed;
                        is_push <= (i_entry.op == OP_PUSH_ABS);
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (o_cmd_pos == target || o_alarm_overflow) state <= ST_DONE;
                end
                // wait for start release so one press runs one entry
                ST_DONE: if (!start_s) state <= ST_READY;
                default: state <= ST_READY;
            endcase
        end
    end

    assign o_ready = (state == ST_READY);
    assign step_run = (state == ST_RUN) && (o_cmd_pos != target);

    step_gen u_step_gen (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_run(step_run),
        .i_rate_hz(rate),
        .o_step(step_pulse)
    );

    // command position follows emitted steps
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cmd_pos <= '0;
            o_step <= 1'b0;
        end else begin
            o_step <= step_pulse && step_run;
            if (step_pulse && step_run) begin
                o_cmd_pos <= next_cmd_pos;
            end
        end
    end

    // wrap zero pulse where a step lands on a range/count boundary
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wrap_zero_pulse <= 1'b0;
        end else begin
            o_wrap_zero_pulse <= 1'b0;
            if (step_pulse && step_run && wrap_on && zero_spacing != 32'h0) begin
                o_wrap_zero_pulse <= (wrap_mod(64'(next_cmd_pos), 64'(zero_spacing)) == 64'sd0);
            end
        end
    end

    // alarms and push flag: cleared at next accepted start, set wins
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_alarm_data_err <= 1'b0;
            o_alarm_overflow <= 1'b0;
            o_push_done_flag <= 1'b0;
        end else begin
            if (state == ST_LOAD && (trav_w > 64'sd2147483647 ||
                                     trav_w < -64'sd2147483648)) begin
                o_alarm_data_err <= 1'b1;
            end else if (state == ST_READY && start_s) begin
                o_alarm_data_err <= 1'b0;
            end
            if (state == ST_RUN && is_push && dev > 64'(i_dev_limit)) begin
                o_alarm_overflow <= 1'b1;
            end else if (state == ST_READY && start_s) begin
                o_alarm_overflow <= 1'b0;
            end
            if (state == ST_RUN && is_push && load_s) begin
                o_push_done_flag <= 1'b1;
            end else if (state == ST_READY && start_s) begin
                o_push_done_flag <= 1'b0;
            end
        end
    end

    ready_falls_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        o_ready && start_s |=> !o_ready) else $error("ready did not drop on start");
    ignore_busy_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        !o_ready && state != ST_DONE |=> $stable(o_entry_addr))
        else $error("entry changed while busy");
    ready_returns_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        state == ST_DONE && !start_s |=> o_ready) else $error("ready not restored");
    push_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        state == ST_RUN && o_cmd_pos == target |=> state == ST_DONE)
        else $error("no stop at target");
    rvs_dir_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        state == ST_LOAD && i_entry.op == OP_WRAP_RVS && i_wrap.enable && !o_alarm_data_err
        |=> !o_dir_fwd || target == $past(o_cmd_pos)) else $error("reverse type went forward");
    fwd_dir_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        state == ST_LOAD && i_entry.op == OP_WRAP_FWD && i_wrap.enable |=> o_dir_fwd)
        else $error("forward type went reverse");
    speed_abs_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        state == ST_RUN |-> !rate[`SEQ_SPEED_W-1]) else $error("rate negative");
    overflow_halt_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        $rose(o_alarm_overflow) |-> ##[0:1] state == ST_DONE)
        else $error("overflow did not end run");
endmodule // pos_sequencer
`default_nettype wire

// ---- positioning_operation_sequencer_tb.sv ----
// self-checking bench for the positioning operation sequencer
`timescale 1ns/1ns
`default_nettype none
module positioning_operation_sequencer_tb;
    import seq_pkg::*;
    localparam logic [31:0] SPD = 32'h00BE_BC20;
    localparam logic [31:0] NSPD = 32'hFF41_43E0;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_start;
    logic [7:0] i_entry_select_inputs;
    logic o_ready;
    op_entry_t i_entry;
    wrap_cfg_t i_wrap = '{1'b0, 16'h0001, 16'h0032, 32'h0000_0000, 8'h01};
    logic signed [31:0] i_feedback_pos = 32'h0000_000A;
    logic i_load_contact = 1'b0;
    logic [31:0] i_dev_limit = 32'h0000_03E8;
    logic [7:0] o_entry_addr;
    logic signed [31:0] o_cmd_pos;
    logic o_step, o_dir_fwd, o_push_done_flag, o_wrap_zero_pulse;
    logic o_alarm_data_err, o_alarm_overflow;
    op_entry_t tbl [16];
    int error_cnt = 0;
    int tests_run = 0;
    int gap = 0, gmin = 0, gmax = 0, nst = 0, zcnt = 0;
    logic [31:0] saved;

    always #4 i_sys_clk = ~i_sys_clk;
    assign i_entry = tbl[o_entry_addr[3:0]];

    pos_host u_pos_host (.i_sys_clk(i_sys_clk), .i_ready(o_ready), .o_start(i_start),
        .o_select(i_entry_select_inputs));
    pos_sequencer u_pos_sequencer (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_start(i_start),
        .i_entry_select_inputs(i_entry_select_inputs), .o_ready(o_ready), .i_entry(i_entry),
        .i_wrap(i_wrap), .i_feedback_pos(i_feedback_pos), .i_load_contact(i_load_contact),
        .i_dev_limit(i_dev_limit), .o_entry_addr(o_entry_addr), .o_cmd_pos(o_cmd_pos),
        .o_step(o_step), .o_dir_fwd(o_dir_fwd), .o_push_done_flag(o_push_done_flag),
        .o_wrap_zero_pulse(o_wrap_zero_pulse), .o_alarm_data_err(o_alarm_data_err),
        .o_alarm_overflow(o_alarm_overflow));

    // step spacing and zero-pulse counts; first step only opens the window
    always @(posedge i_sys_clk) begin
        gap <= gap + 1;
        if (o_step === 1'b1) begin
            if (nst > 0 && gap < gmin) gmin <= gap;
            if (nst > 0 && gap > gmax) gmax <= gap;
            nst <= nst + 1;
            gap <= 1;
        end
        if (o_wrap_zero_pulse === 1'b1) zcnt <= zcnt + 1;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("errors %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // run one entry and compare end position, direction and latched number
    task automatic go(input logic [7:0] num, input bit poke, input logic [31:0] pos,
                      input logic dir);
        bit ok;
        zcnt = 0;
        nst = 0;
        gmin = 1000;
        gmax = 0;
        u_pos_host.run_entry(num, poke, ok);
        check("handshake", 32'h1, {31'h0, ok});
        check("entry_addr", {24'h0, num}, {24'h0, o_entry_addr});
        check("cmd_pos", pos, o_cmd_pos);
        check("dir_fwd", {31'h0, dir}, {31'h0, o_dir_fwd});
    endtask

    initial begin
        tbl[0] = '{OP_ABS, 32'h0000_0014, SPD};
        tbl[1] = '{OP_INC_CMD, 32'h0000_0005, SPD};
        tbl[2] = '{OP_INC_FB, 32'h0000_0003, SPD};
        tbl[3] = '{OP_WRAP_FWD, 32'h0000_0005, SPD};
        tbl[4] = '{OP_WRAP_RVS, 32'h0000_000A, SPD};
        tbl[5] = '{OP_WRAP_NEAR, 32'h0000_005A, SPD};
        tbl[6] = '{OP_WRAP_ABS, 32'h0000_005F, SPD};
        tbl[7] = '{OP_PUSH_ABS, 32'h0000_0064, NSPD};
        tbl[8] = '{OP_PUSH_ABS, 32'h0000_00C8, SPD};
        tbl[9] = '{OP_PUSH_ABS, 32'h8000_0000, SPD};
        for (int k = 10; k < 16; k++) tbl[k] = '{OP_ABS, 32'h0000_0000, SPD};
        // entries are never linked here, so no current step-up between them
        repeat (2) @(negedge i_sys_clk);
        check("ready_in_reset", 32'h1, {31'h0, o_ready});
        i_rstn = 1'b1;
        @(negedge i_sys_clk);
        go(8'h00, 1'b1, 32'h0000_0014, 1'b1);
        go(8'h01, 1'b0, 32'h0000_0019, 1'b1);
        go(8'h02, 1'b0, 32'h0000_000D, 1'b0);
        i_wrap.enable = 1'b1;
        go(8'h03, 1'b0, 32'h0000_0005, 1'b1);
        check("zero_pulses_fwd", 32'h1, zcnt);
        go(8'h04, 1'b0, 32'h0000_000A, 1'b0);
        check("zero_pulses_rvs", 32'h1, zcnt);
        go(8'h05, 1'b0, 32'h0000_005A, 1'b0);
        go(8'h06, 1'b0, 32'h0000_005F, 1'b1);
        i_wrap.enable = 1'b0;
        i_load_contact = 1'b1;
        go(8'h07, 1'b0, 32'h0000_0064, 1'b1);
        check("step_gap_ok", 32'h1, {31'h0, (gmin >= 9 && gmax <= 11 && nst == 5)});
        check("push_done", 32'h1, {31'h0, o_push_done_flag});
        check("no_overflow", 32'h0, {31'h0, o_alarm_overflow});
        i_load_contact = 1'b0;
        i_dev_limit = 32'h0000_0004;
        u_pos_host.run_entry(8'h08, 1'b0, saved[0]);
        check("handshake_push", 32'h1, {31'h0, saved[0]});
        check("overflow_alarm", 32'h1, {31'h0, o_alarm_overflow});
        // deviation is over the limit at once, so the run ends before any step
        check("push_stopped", 32'h0000_0064, o_cmd_pos);
        check("push_done_clear", 32'h0, {31'h0, o_push_done_flag});
        // refused travel: no motion, direction kept from the forward push
        go(8'h09, 1'b0, 32'h0000_0064, 1'b1);
        check("data_err", 32'h1, {31'h0, o_alarm_data_err});
        check("overflow_cleared", 32'h0, {31'h0, o_alarm_overflow});
        report_and_stop();
    end

    initial begin
        repeat (30000) @(posedge i_sys_clk);
        error_cnt++;
        report_and_stop();
    end
endmodule // positioning_operation_sequencer_tb
`default_nettype wire

// ---- seq_params.svh ----
// constants for the positioning operation sequencer
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
`define SEQ_ENTRY_W 8
`define SEQ_POS_W 32
`define SEQ_SPEED_W 32
`define SEQ_TYPE_W 4
`define SEQ_DEV_W 32
`define SEQ_STEPS_PER_REV 32'h0000_0064
`define SEQ_CLK_HZ 125000000
`define SEQ_STEP_ACC_W 40
`endif

// ---- seq_pkg.sv ----
// types for the positioning operation sequencer
`include "seq_params.svh"
package seq_pkg;
    typedef enum logic [3:0] {
        OP_ABS = 4'h0,
        OP_INC_CMD = 4'h1,
        OP_INC_FB = 4'h2,
        OP_WRAP_ABS = 4'h3,
        OP_WRAP_NEAR = 4'h4,
        OP_WRAP_FWD = 4'h5,
        OP_WRAP_RVS = 4'h6,
        OP_PUSH_ABS = 4'h7
    } op_type_t;

    typedef struct packed {
        op_type_t op;
        logic signed [`SEQ_POS_W-1:0] position;
        logic signed [`SEQ_SPEED_W-1:0] speed;
    } op_entry_t;

    typedef struct packed {
        logic enable;
        logic [15:0] range_rev;
        logic [15:0] offset_pct;
        logic signed [31:0] round_offset;
        logic [7:0] zero_pulses;
    } wrap_cfg_t;

    typedef enum logic [1:0] {
        ST_READY = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN = 2'b11,
        ST_DONE = 2'b10
    } seq_state_t;
endpackage

// ---- step_gen.sv ----
// constant-rate step pulse generator
`timescale 1ns/1ns
`default_nettype none
`include "seq_params.svh"
module step_gen
    import seq_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // control
    input wire logic i_run,
    input wire logic [`SEQ_SPEED_W-1:0] i_rate_hz,
    // step out
    output logic o_step
);
    logic [`SEQ_STEP_ACC_W-1:0] acc;
    logic [`SEQ_STEP_ACC_W-1:0] next_acc;

    // rectangular drive: full rate from the first cycle, no ramp
    always_comb begin
        next_acc = acc + {{(`SEQ_STEP_ACC_W-`SEQ_SPEED_W){1'b0}}, i_rate_hz};
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            acc <= '0;
            o_step <= 1'b0;
        end else if (!i_run) begin
            acc <= '0;
            o_step <= 1'b0;
        end else if (next_acc >= `SEQ_STEP_ACC_W'(`SEQ_CLK_HZ)) begin
            acc <= next_acc - `SEQ_STEP_ACC_W'(`SEQ_CLK_HZ);
            o_step <= 1'b1;
        end else begin
            acc <= next_acc;
            o_step <= 1'b0;
        end
    end
endmodule // step_gen
`default_nettype wire
